// *** rtl/lnbd_pkg.sv ***
// Shared constants and types of the diagnostic status block
package lnbd_pkg;
    // Register map
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h01;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Status field positions
    localparam int OVERLOAD_BIT = 0;
    localparam int OVERTEMP_BIT = 1;
    localparam int VOUT_LOW_BIT = 2;
    localparam int SUPPLY_GOOD_BIT = 3;
    localparam int PULLDOWN_OC_BIT = 4;
    // Bus address, low bit taken from the address select pin
    localparam logic [6:0] DEV_ADDR_BASE = 7'h08;
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int TOFF_MS = 900;
    localparam int TOFF_CYC = TOFF_MS * (CLK_HZ / 1000);
    localparam int TON_CYC = TOFF_CYC / 10;
    localparam int PDO_TIMEOUT_MS = 10;
    localparam int PDO_CYC = PDO_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int TONE_HZ = 22_000;
    localparam int TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);

    typedef enum {I2C_IDLE, I2C_ADDR, I2C_ACK_ADDR, I2C_WRITE, I2C_ACK_WRITE,
                  I2C_READ, I2C_READ_ACK} lnbd_i2c_e;
    typedef enum {PROT_IDLE, PROT_OFF, PROT_ON} lnbd_prot_e;

    // Asynchronous pin inputs, synchronised together
    typedef struct packed {
        logic scl;
        logic sda;
        logic addr_sel;
        logic overload;
        logic short_circuit;
        logic temp_hot;
        logic temp_cool;
        logic vout_low;
        logic vcc_rise;
        logic vcc_fall;
        logic pulldown_oc;
        logic tone_enable_input;
    } lnbd_pins_s;
endpackage

// *** rtl/lnbd_status.sv ***
// Diagnostic status register with bus slave, overload cycling and tone
`timescale 1ns/1ps
`default_nettype none
module lnbd_status #(
    parameter int TOFF_CYCLES = lnbd_pkg::TOFF_CYC,
    parameter int TON_CYCLES = lnbd_pkg::TON_CYC,
    parameter int PDO_CYCLES = lnbd_pkg::PDO_CYC,
    parameter int TONE_HALF = lnbd_pkg::TONE_HALF_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_sel_i,
    input wire logic overload_i,
    input wire logic short_circuit_i,
    input wire logic temp_hot_i,
    input wire logic temp_cool_i,
    input wire logic vout_low_i,
    input wire logic vcc_rise_i,
    input wire logic vcc_fall_i,
    input wire logic pulldown_oc_i,
    input wire logic tone_enable_input_i,
    output logic output_enable_o,
    output logic tone_o,
    output logic [7:0] diagnostic_status_o
);
    localparam int PCW = $clog2(TOFF_CYCLES + 1);
    localparam int DCW = $clog2(PDO_CYCLES + 1);
    localparam int TCW = $clog2(TONE_HALF + 1);
    localparam logic [PCW-1:0] TOFF_LAST = PCW'(TOFF_CYCLES - 1);
    localparam logic [PCW-1:0] TON_LAST = PCW'(TON_CYCLES - 1);
    localparam logic [DCW-1:0] PDO_LAST = DCW'(PDO_CYCLES - 1);
    localparam logic [TCW-1:0] TONE_LAST = TCW'(TONE_HALF - 1);
    typedef struct packed {
        logic scl_prev;
        logic sda_prev;
        lnbd_pkg::lnbd_i2c_e i2c;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic ptr_phase;
        logic master_ack;
        logic [7:0] data_reg;
        logic sda_oe;
        logic sda_out;
        lnbd_pkg::lnbd_prot_e prot;
        logic [PCW-1:0] prot_cnt;
        logic [DCW-1:0] pdo_cnt;
        logic [TCW-1:0] tone_cnt;
        logic tone;
        logic out_en;
        logic [7:0] status;
    } lnbd_state_s;
    lnbd_state_s r;
    lnbd_state_s next_r;
    lnbd_pkg::lnbd_pins_s pins_raw;
    lnbd_pkg::lnbd_pins_s pins;
    function automatic logic [7:0] read_byte(input logic [7:0] addr, input logic [7:0] status,
                                             input logic [7:0] data);
        if (addr == lnbd_pkg::REG_STATUS) begin
            read_byte = status;
        end else if (addr == lnbd_pkg::REG_DATA) begin
            read_byte = data;
        end else begin
            read_byte = 8'h00;
        end
    endfunction
    assign pins_raw = '{scl: scl_i, sda: sda_i, addr_sel: addr_sel_i, overload: overload_i,
                        short_circuit: short_circuit_i, temp_hot: temp_hot_i,
                        temp_cool: temp_cool_i, vout_low: vout_low_i, vcc_rise: vcc_rise_i,
                        vcc_fall: vcc_fall_i, pulldown_oc: pulldown_oc_i,
                        tone_enable_input: tone_enable_input_i};
    lnbd_sync #(
        .WIDTH($bits(lnbd_pkg::lnbd_pins_s))
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .d_i(pins_raw),
        .q_o(pins)
    );
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_cond;
        logic stop_cond;
        logic [7:0] rd;
        scl_rise = pins.scl && !r.scl_prev;
        scl_fall = !pins.scl && r.scl_prev;
        start_cond = pins.scl && r.scl_prev && r.sda_prev && !pins.sda;
        stop_cond = pins.scl && r.scl_prev && !r.sda_prev && pins.sda;
        rd = 8'h00;
        next_r = r;
        next_r.scl_prev = pins.scl;
        next_r.sda_prev = pins.sda;
        next_r.sda_out = 1'b0;
        if (start_cond) begin
            next_r.i2c = lnbd_pkg::I2C_ADDR;
            next_r.bit_cnt = 4'h0;
            next_r.sda_oe = 1'b0;
        end else if (stop_cond) begin
            next_r.i2c = lnbd_pkg::I2C_IDLE;
            next_r.sda_oe = 1'b0;
        end else begin
            case (r.i2c)
                lnbd_pkg::I2C_IDLE: begin
                    next_r.sda_oe = 1'b0;
                end
                lnbd_pkg::I2C_ADDR, lnbd_pkg::I2C_WRITE: begin
                    if (scl_rise && r.bit_cnt < 4'h8) begin
                        next_r.shreg = {r.shreg[6:0], pins.sda};
                        next_r.bit_cnt = r.bit_cnt + 4'h1;
                    end else if (scl_fall && r.bit_cnt == 4'h8) begin
                        if (r.i2c == lnbd_pkg::I2C_ADDR) begin
                            if (r.shreg[7:1] == {lnbd_pkg::DEV_ADDR_BASE[6:1], pins.addr_sel}) begin
                                next_r.sda_oe = 1'b1;
                                next_r.master_ack = r.shreg[0];
                                next_r.i2c = lnbd_pkg::I2C_ACK_ADDR;
                            end else begin
                                next_r.i2c = lnbd_pkg::I2C_IDLE;
                            end
                        end else begin
                            next_r.sda_oe = 1'b1;
                            next_r.i2c = lnbd_pkg::I2C_ACK_WRITE;
                            if (r.ptr_phase) begin
                                next_r.ptr = r.shreg;
                                next_r.ptr_phase = 1'b0;
                            end else begin
                                if (r.ptr == lnbd_pkg::REG_DATA) begin
                                    next_r.data_reg = r.shreg;
                                end
                                next_r.ptr = r.ptr + 8'h01;
                            end
                        end
                    end
                end
                lnbd_pkg::I2C_ACK_ADDR: begin
                    if (scl_fall) begin
                        next_r.bit_cnt = 4'h0;
                        if (r.master_ack) begin
                            rd = read_byte(r.ptr, r.status, r.data_reg);
                            next_r.shreg = rd;
                            next_r.sda_oe = !rd[7];
                            next_r.i2c = lnbd_pkg::I2C_READ;
                        end else begin
                            next_r.sda_oe = 1'b0;
                            next_r.ptr_phase = 1'b1;
                            next_r.i2c = lnbd_pkg::I2C_WRITE;
                        end
                    end
                end
                lnbd_pkg::I2C_ACK_WRITE: begin
                    if (scl_fall) begin
                        next_r.sda_oe = 1'b0;
                        next_r.bit_cnt = 4'h0;
                        next_r.i2c = lnbd_pkg::I2C_WRITE;
                    end
                end
                lnbd_pkg::I2C_READ: begin
                    if (scl_fall) begin
                        if (r.bit_cnt == 4'h7) begin
                            next_r.sda_oe = 1'b0;
                            next_r.ptr = r.ptr + 8'h01;
                            next_r.i2c = lnbd_pkg::I2C_READ_ACK;
                        end else begin
                            next_r.shreg = {r.shreg[6:0], 1'b0};
                            next_r.sda_oe = !r.shreg[6];
                            next_r.bit_cnt = r.bit_cnt + 4'h1;
                        end
                    end
                end
                lnbd_pkg::I2C_READ_ACK: begin
                    if (scl_rise) begin
                        next_r.master_ack = !pins.sda;
                    end else if (scl_fall) begin
                        // Next byte only while the master acknowledges
                        if (r.master_ack) begin
                            rd = read_byte(r.ptr, r.status, r.data_reg);
                            next_r.shreg = rd;
                            next_r.sda_oe = !rd[7];
                            next_r.bit_cnt = 4'h0;
                            next_r.i2c = lnbd_pkg::I2C_READ;
                        end else begin
                            next_r.i2c = lnbd_pkg::I2C_IDLE;
                        end
                    end
                end
                default: begin
                    next_r.i2c = lnbd_pkg::I2C_IDLE;
                    next_r.sda_oe = 1'b0;
                end
            endcase
        end
        case (r.prot)
            lnbd_pkg::PROT_IDLE: begin
                next_r.prot_cnt = '0;
                if (pins.short_circuit) begin
                    next_r.prot = lnbd_pkg::PROT_OFF;
                end
            end
            lnbd_pkg::PROT_OFF: begin
                next_r.prot_cnt = r.prot_cnt + PCW'(1);
                if (r.prot_cnt == TOFF_LAST) begin
                    next_r.prot_cnt = '0;
                    next_r.prot = lnbd_pkg::PROT_ON;
                end
            end
            lnbd_pkg::PROT_ON: begin
                next_r.prot_cnt = r.prot_cnt + PCW'(1);
                if (r.prot_cnt == TON_LAST) begin
                    next_r.prot_cnt = '0;
                    next_r.prot = pins.short_circuit ? lnbd_pkg::PROT_OFF : lnbd_pkg::PROT_IDLE;
                end
            end
            default: begin
                next_r.prot = lnbd_pkg::PROT_IDLE;
            end
        endcase
        next_r.out_en = (next_r.prot != lnbd_pkg::PROT_OFF);
        if (!pins.pulldown_oc) begin
            next_r.pdo_cnt = '0;
        end else if (r.pdo_cnt <= PDO_LAST) begin
            next_r.pdo_cnt = r.pdo_cnt + DCW'(1);
        end
        if (!pins.tone_enable_input) begin
            next_r.tone_cnt = '0;
            next_r.tone = 1'b0;
        end else if (r.tone_cnt == TONE_LAST) begin
            next_r.tone_cnt = '0;
            next_r.tone = !r.tone;
        end else begin
            next_r.tone_cnt = r.tone_cnt + TCW'(1);
        end
        next_r.status[lnbd_pkg::OVERLOAD_BIT] = pins.overload || (r.prot != lnbd_pkg::PROT_IDLE);
        if (pins.temp_hot) begin
            next_r.status[lnbd_pkg::OVERTEMP_BIT] = 1'b1;
        end else if (pins.temp_cool) begin
            next_r.status[lnbd_pkg::OVERTEMP_BIT] = 1'b0;
        end
        next_r.status[lnbd_pkg::VOUT_LOW_BIT] = pins.vout_low;
        // Supply good, rising and falling thresholds
        if (pins.vcc_rise) begin
            next_r.status[lnbd_pkg::SUPPLY_GOOD_BIT] = 1'b1;
        end else if (pins.vcc_fall) begin
            next_r.status[lnbd_pkg::SUPPLY_GOOD_BIT] = 1'b0;
        end
        next_r.status[lnbd_pkg::PULLDOWN_OC_BIT] = (r.pdo_cnt > PDO_LAST);
        next_r.status[7:5] = 3'h0;
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            r <= '0;
            r.i2c <= lnbd_pkg::I2C_IDLE;
            r.prot <= lnbd_pkg::PROT_IDLE;
            r.scl_prev <= 1'b1;
            r.sda_prev <= 1'b1;
            r.data_reg <= lnbd_pkg::DATA_RESET;
            r.out_en <= 1'b1;
            r.status <= lnbd_pkg::STATUS_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign sda_o = r.sda_out;
    assign sda_oe_o = r.sda_oe;
    assign output_enable_o = r.out_en;
    assign tone_o = r.tone;
    assign diagnostic_status_o = r.status;
endmodule // lnbd_status
`default_nettype wire

// *** rtl/lnbd_sync.sv ***
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module lnbd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] q;
    } lnbd_sync_s;

    lnbd_sync_s r;
    lnbd_sync_s next_r;

    always_comb begin
        next_r.meta = d_i;
        next_r.q = r.meta;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q_o = r.q;
endmodule // lnbd_sync
`default_nettype wire

// *** sim/lnbd_i2c_master.sv ***
// Two-wire bus master model facing the status block
`timescale 1ns/1ps
`default_nettype none
module lnbd_i2c_master (
    input wire logic clk_sys_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tk(input int k);
        repeat (k) @(posedge clk_sys_i);
    endtask
    // one clock pulse, SCL low well over 5 clocks
    task automatic bit_x(input logic b, output logic r);
        sda_low_o <= ~b;
        tk(4);
        scl_o <= 1'b1;
        tk(4);
        r = sda_i;
        tk(4);
        scl_o <= 1'b0;
        tk(4);
    endtask
    task automatic start_c();
        sda_low_o <= 1'b0;
        scl_o <= 1'b1;
        tk(8);
        sda_low_o <= 1'b1;
        tk(8);
        scl_o <= 1'b0;
        tk(4);
    endtask
    task automatic stop_c();
        sda_low_o <= 1'b1;
        tk(4);
        scl_o <= 1'b1;
        tk(8);
        sda_low_o <= 1'b0;
        tk(8);
    endtask
    // MSB first, ninth bit is the acknowledge
    task automatic byte_x(input logic [7:0] b, input logic last, output logic [7:0] r,
                          output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], r[i]);
        end
        bit_x(last, ack);
    endtask
    // pointer write, then a data byte, or with rd a stop and two bytes read ending on a nack
    task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr, input logic rd,
                        input logic [7:0] wd, output logic [7:0] b0, output logic [7:0] b1,
                        output logic nak);
        logic [7:0] r;
        logic a;
        start_c();
        byte_x({dev, 1'b0}, 1'b1, r, nak);
        byte_x(ptr, 1'b1, r, a);
        if (rd) begin
            stop_c();
            start_c();
            byte_x({dev, 1'b1}, 1'b1, r, a);
            byte_x(8'hff, 1'b0, b0, a);
            byte_x(8'hff, 1'b1, b1, a);
        end else begin
            byte_x(wd, 1'b1, r, a);
        end
        stop_c();
    endtask
endmodule // lnbd_i2c_master
`default_nettype wire

// *** sim/lnbd_status_sva.sv ***
// Port-level assertions for the diagnostic status block
`timescale 1ns/1ps
`default_nettype none
module lnbd_status_sva #(
    parameter int TOFF_CYCLES = 100,
    parameter int PDO_CYCLES = 20
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic overload_i,
    input wire logic temp_hot_i,
    input wire logic temp_cool_i,
    input wire logic vout_low_i,
    input wire logic vcc_rise_i,
    input wire logic vcc_fall_i,
    input wire logic pulldown_oc_i,
    input wire logic tone_enable_input_i,
    input wire logic sda_o,
    input wire logic output_enable_o,
    input wire logic tone_o,
    input wire logic [7:0] diagnostic_status_o
);
    logic [2:0] rcnt;
    int pcnt;
    int lcnt;
    logic ok;
    // Cycles since reset, pin run length, off-phase length
    always_ff @(posedge clk_sys_i) begin
        rcnt <= rst_i ? 3'h0 : (rcnt == 3'h7 ? rcnt : rcnt + 3'h1);
        pcnt <= (rst_i || !pulldown_oc_i) ? 0 : pcnt + 1;
        lcnt <= (rst_i || output_enable_o) ? 0 : lcnt + 1;
    end
    assign ok = rcnt >= 3'h4;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    property p_rst_val;
        $past(rst_i) |-> diagnostic_status_o == 8'h00 && output_enable_o && !tone_o;
    endproperty
    a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
    property p_rsvd;
        diagnostic_status_o[7:5] == 3'h0 && sda_o == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_vlow;
        ok |-> diagnostic_status_o[2] == $past(vout_low_i, 3);
    endproperty
    a_vlow: assert property (p_vlow) else $error("voltage flag wrong");
    property p_ovl;
        ok && $past(overload_i, 3) |-> diagnostic_status_o[0];
    endproperty
    a_ovl: assert property (p_ovl) else $error("overload flag missing");
    property p_ot_set;
        ok && $past(temp_hot_i, 3) |-> diagnostic_status_o[1];
    endproperty
    a_ot_set: assert property (p_ot_set) else $error("overtemp not set");
    property p_ot_clr;
        ok && $past(temp_cool_i, 3) && !$past(temp_hot_i, 3) |-> !diagnostic_status_o[1];
    endproperty
    a_ot_clr: assert property (p_ot_clr) else $error("overtemp not cleared");
    property p_pg;
        ok && $past(vcc_rise_i, 3) |-> diagnostic_status_o[3];
    endproperty
    a_pg: assert property (p_pg) else $error("supply flag not set");
    property p_pg_clr;
        ok && $past(vcc_fall_i, 3) && !$past(vcc_rise_i, 3) |-> !diagnostic_status_o[3];
    endproperty
    a_pg_clr: assert property (p_pg_clr) else $error("supply flag not cleared");
    property p_pdo_clr;
        ok && !$past(pulldown_oc_i, 4) |-> !diagnostic_status_o[4];
    endproperty
    a_pdo_clr: assert property (p_pdo_clr) else $error("pull-down flag stuck");
    property p_pdo_wait;
        $rose(diagnostic_status_o[4]) |-> pcnt > PDO_CYCLES && pcnt <= PDO_CYCLES + 4;
    endproperty
    a_pdo_wait: assert property (p_pdo_wait) else $error("pull-down flag early");
    property p_toff;
        $rose(output_enable_o) |-> lcnt == TOFF_CYCLES;
    endproperty
    a_toff: assert property (p_toff) else $error("off phase length wrong");
    property p_off_flag;
        !output_enable_o [*2] |-> diagnostic_status_o[0];
    endproperty
    a_off_flag: assert property (p_off_flag) else $error("no flag while off");
    property p_tone_off;
        (!tone_enable_input_i) [*6] |=> !tone_o;
    endproperty
    a_tone_off: assert property (p_tone_off) else $error("tone while disabled");
endmodule // lnbd_status_sva
bind lnbd_status lnbd_status_sva #(.TOFF_CYCLES(TOFF_CYCLES), .PDO_CYCLES(PDO_CYCLES)) u_sva (
    .clk_sys_i, .rst_i, .overload_i, .temp_hot_i, .temp_cool_i, .vout_low_i, .vcc_rise_i,
    .vcc_fall_i, .pulldown_oc_i, .tone_enable_input_i, .sda_o, .output_enable_o, .tone_o,
    .diagnostic_status_o);
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench of the diagnostic status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    lnbd_pkg::lnbd_pins_s pin = '0;
    logic scl, m_low, sda_o, sda_oe_o, output_enable_o, tone_o, nak, t, ot, pg;
    wire logic sda = ~(m_low | sda_oe_o);
    logic [7:0] diagnostic_status_o, b0, b1, d, r, e;
    int seed = 32'hdafd;
    int err_total = 0;
    int n_tests = 0;
    int n;
    always #12.5 clk_sys_i = ~clk_sys_i;
    lnbd_status #(.TOFF_CYCLES(100), .TON_CYCLES(10), .PDO_CYCLES(20), .TONE_HALF(4)) dut (
        .clk_sys_i, .rst_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o,
        .addr_sel_i(pin.addr_sel), .overload_i(pin.overload),
        .short_circuit_i(pin.short_circuit), .temp_hot_i(pin.temp_hot),
        .temp_cool_i(pin.temp_cool), .vout_low_i(pin.vout_low), .vcc_rise_i(pin.vcc_rise),
        .vcc_fall_i(pin.vcc_fall), .pulldown_oc_i(pin.pulldown_oc),
        .tone_enable_input_i(pin.tone_enable_input), .output_enable_o, .tone_o,
        .diagnostic_status_o);
    lnbd_i2c_master mst (.clk_sys_i, .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
    task automatic tk(input int k);
        repeat (k) @(posedge clk_sys_i);
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Counts samples while the output stage stays at the given level
    task automatic lvl(input logic v);
        n = 0;
        while (output_enable_o === v && n < 1000) begin
            tk(1);
            n++;
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        tk(30000);
        err_total++;
        test_done();
    end
    initial begin
        ot = 1'b0;
        pg = 1'b0;
        tk(3);
        rst_i <= 1'b0;
        tk(3);
        chk(diagnostic_status_o, 8'h00);
        chk({6'h00, output_enable_o, tone_o}, 8'h02);
        repeat (24) begin
            r = 8'($random(seed));
            pin.overload <= r[0];
            pin.temp_hot <= r[1];
            pin.temp_cool <= r[2];
            pin.vout_low <= r[3];
            pin.vcc_rise <= r[4];
            pin.vcc_fall <= r[5];
            ot = r[1] | (ot & ~r[2]);
            pg = r[4] | (pg & ~r[5]);
            e = {4'h0, pg, r[3], ot, r[0]};
            tk(5);
            chk(diagnostic_status_o, e);
        end
        d = 8'($random(seed));
        mst.xfer(7'h08, 8'h01, 1'b0, d, b0, b1, nak);
        chk({7'h00, nak}, 8'h00);
        mst.xfer(7'h08, 8'h00, 1'b0, 8'hff, b0, b1, nak);
        pin.addr_sel <= 1'b1;
        mst.xfer(7'h08, 8'h01, 1'b0, 8'h5a, b0, b1, nak);
        chk({7'h00, nak}, 8'h01);
        mst.xfer(7'h09, 8'h00, 1'b1, 8'h00, b0, b1, nak);
        chk(b0, e);
        chk(b1, d);
        chk(diagnostic_status_o, e);
        pin.pulldown_oc <= 1'b1;
        tk(15);
        chk({7'h00, diagnostic_status_o[4]}, 8'h00);
        tk(15);
        chk({7'h00, diagnostic_status_o[4]}, 8'h01);
        pin.pulldown_oc <= 1'b0;
        pin.overload <= 1'b0;
        tk(5);
        chk({7'h00, diagnostic_status_o[4]}, 8'h00);
        pin.short_circuit <= 1'b1;
        lvl(1'b1);
        tk(5);
        chk({6'h00, output_enable_o, diagnostic_status_o[0]}, 8'h01);
        lvl(1'b0);
        chk(8'(n), 8'h5f);
        lvl(1'b1);
        chk(8'(n), 8'h0a);
        pin.short_circuit <= 1'b0;
        lvl(1'b0);
        tk(40);
        chk({6'h00, output_enable_o, diagnostic_status_o[0]}, 8'h02);
        pin.tone_enable_input <= 1'b1;
        tk(8);
        n = 0;
        repeat (80) begin
            t = tone_o;
            tk(1);
            n += (tone_o !== t);
        end
        chk(8'(n), 8'h14);
        pin.tone_enable_input <= 1'b0;
        tk(8);
        chk({7'h00, tone_o}, 8'h00);
        test_done();
    end
endmodule // tb_top
`default_nettype wire
